// ===== wvs_map.vh
`ifndef WVS_MAP_VH
`define WVS_MAP_VH
// Command codes on cmd_code
`define WVS_CMD_NOP        4'h0
`define WVS_CMD_WELD_X     4'h1
`define WVS_CMD_WELD_Y     4'h2
`define WVS_CMD_WELD_STEP  4'h3
`define WVS_CMD_WELD_DELAY 4'h4
`define WVS_CMD_WELD_PULSE 4'h5
`define WVS_CMD_EXEC_LIST  4'h6
`define WVS_CMD_EXEC_CLEAR 4'h7
`define WVS_CMD_EXEC_REPEAT 4'h8
// Argument limits and defaults
`define WVS_STEP_MIN       16'h0001
`define WVS_STEP_MAX       16'h7FFF
`define WVS_STEP_RST       15'h0200
`define WVS_DELAY_MIN      16'h0002
`define WVS_DELAY_MAX      16'hFFFE
`define WVS_DELAY_RST      16'h0BB8
`define WVS_PULSE_MIN      16'h0014
`define WVS_PULSE_MAX      16'hFFFE
`define WVS_PULSE_RST      16'h01F4
// List depths
`define WVS_VEC_DEPTH      32767
`define WVS_PULSE_DEPTH    16383
// Timing
`define WVS_CLK_MHZ        250
`define WVS_US_NS          1000
`define WVS_CLK_NS          4
`define WVS_CYC_PER_US     (`WVS_US_NS / `WVS_CLK_NS)
`define WVS_US_LAST        8'hF9
`endif

// ===== wvs_axis.v
`timescale 1ns/1ps
module wvs_axis (
    sys_clk,
    rst,
    step_tick,
    target,
    step_size,
    pos_q,
    at_target
);
    input  wire        sys_clk;
    input  wire        rst;
    input  wire        step_tick;
    input  wire [15:0] target;
    input  wire [14:0] step_size;
    output reg  [15:0] pos_q;
    output wire        at_target;

    wire [16:0] dist_up = {1'b0, target} - {1'b0, pos_q};
    wire [16:0] dist_dn = {1'b0, pos_q} - {1'b0, target};
    wire [16:0] step_w  = {2'b00, step_size};

    assign at_target = (pos_q == target);

    // One increment per step tick, last step lands on target
    always @(posedge sys_clk)
    begin
        if (rst)
            pos_q <= 16'h0000;
        else if (step_tick && !at_target)
        begin
            if (target > pos_q)
                pos_q <= (dist_up <= step_w) ? target : pos_q + {1'b0, step_size};
            else
                pos_q <= (dist_dn <= step_w) ? target : pos_q - {1'b0, step_size};
        end
    end
endmodule // wvs_axis

// ===== wvs_top.v
`timescale 1ns/1ps
`include "wvs_map.vh"
module wvs_top (
    sys_clk,
    rst,
    cmd_valid,
    cmd_code,
    cmd_arg,
    step_period_setting,
    cmd_ready,
    weld_x_out,
    weld_y_out,
    laser_enable_out,
    busy,
    list_full
);
    input  wire        sys_clk;
    input  wire        rst;
    input  wire        cmd_valid;
    input  wire [3:0]  cmd_code;
    input  wire [15:0] cmd_arg;
    input  wire [15:0] step_period_setting;
    output reg         cmd_ready;
    output reg  [15:0] weld_x_out;
    output reg  [15:0] weld_y_out;
    output reg         laser_enable_out;
    output reg         busy;
    output reg         list_full;

    localparam [2:0] ST_IDLE   = 3'd0;
    localparam [2:0] ST_FETCH  = 3'd1;
    localparam [2:0] ST_PULSE  = 3'd2;
    localparam [2:0] ST_MOVE   = 3'd3;
    localparam [2:0] ST_SETTLE = 3'd4;
    localparam [2:0] ST_BURN   = 3'd5;
    localparam [7:0] US_LAST   = `WVS_US_LAST;

    // Vector entry: x, y, step, pulse valid, pulse index
    reg  [61:0] vec_mem [0:`WVS_VEC_DEPTH-1];
    reg  [15:0] pulse_mem [0:`WVS_PULSE_DEPTH-1];

    reg  [2:0]  state_q;
    reg  [14:0] vec_cnt_q;
    reg  [13:0] pulse_cnt_q;
    reg         pulse_have_q;
    reg  [15:0] pend_x_q;
    reg  [14:0] step_q;
    reg  [15:0] delay_q;
    reg  [14:0] idx_q;
    reg         repeat_q;
    reg  [61:0] rd_q;
    reg  [15:0] pulse_rd_q;
    reg  [15:0] tgt_x_q;
    reg  [15:0] tgt_y_q;
    reg  [14:0] tgt_step_q;
    reg  [15:0] burn_len_q;
    reg  [7:0]  pre_q;
    reg  [15:0] us_cnt_q;
    reg         step_tick_q;
    reg  [2:0]  prev_state_q;

    wire [15:0] ax_x;
    wire [15:0] ax_y;
    wire        at_x;
    wire        at_y;
    wire        accept = cmd_valid && cmd_ready;
    wire        us_tick = (pre_q == US_LAST);
    wire [15:0] period = (step_period_setting == 16'h0000) ? 16'h0001 : step_period_setting;
    wire        last_vec = (idx_q == vec_cnt_q - 15'd1);

    wire [15:0] step_clip  = (cmd_arg < `WVS_STEP_MIN) ? `WVS_STEP_MIN :
                             (cmd_arg > `WVS_STEP_MAX) ? `WVS_STEP_MAX : cmd_arg;
    wire [15:0] delay_clip = (cmd_arg < `WVS_DELAY_MIN) ? `WVS_DELAY_MIN :
                             (cmd_arg > `WVS_DELAY_MAX) ? `WVS_DELAY_MAX : cmd_arg;
    wire [15:0] pulse_clip = (cmd_arg < `WVS_PULSE_MIN) ? `WVS_PULSE_MIN :
                             (cmd_arg > `WVS_PULSE_MAX) ? `WVS_PULSE_MAX : cmd_arg;

    wvs_axis u_axis_x (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .step_tick (step_tick_q),
        .target    (tgt_x_q),
        .step_size (tgt_step_q),
        .pos_q     (ax_x),
        .at_target (at_x)
    );

    wvs_axis u_axis_y (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .step_tick (step_tick_q),
        .target    (tgt_y_q),
        .step_size (tgt_step_q),
        .pos_q     (ax_y),
        .at_target (at_y)
    );

    // List storage
    always @(posedge sys_clk)
    begin
        if (accept && cmd_code == `WVS_CMD_WELD_Y && vec_cnt_q != `WVS_VEC_DEPTH)
            vec_mem[vec_cnt_q] <= {pend_x_q, cmd_arg, step_q, pulse_have_q, pulse_cnt_q - 14'd1};
        if (accept && cmd_code == `WVS_CMD_WELD_PULSE && pulse_cnt_q != `WVS_PULSE_DEPTH)
            pulse_mem[pulse_cnt_q] <= pulse_clip;
        rd_q       <= vec_mem[idx_q];
        pulse_rd_q <= pulse_mem[rd_q[13:0]];
    end

    // Command intake; WVS_CMD_NOP, WVS_CMD_EXEC_LIST and WVS_CMD_EXEC_REPEAT fall through untouched
    always @(posedge sys_clk)
    begin
        if (rst || (accept && cmd_code == `WVS_CMD_EXEC_CLEAR))
        begin
            vec_cnt_q    <= 15'd0;
            pulse_cnt_q  <= 14'd0;
            pulse_have_q <= 1'b0;
            pend_x_q     <= 16'h0000;
            step_q       <= `WVS_STEP_RST;
            delay_q      <= `WVS_DELAY_RST;
        end
        else if (accept)
        begin
            case (cmd_code)
                `WVS_CMD_WELD_X:
                    pend_x_q <= cmd_arg;
                `WVS_CMD_WELD_Y:
                    if (vec_cnt_q != `WVS_VEC_DEPTH)
                        vec_cnt_q <= vec_cnt_q + 15'd1;
                `WVS_CMD_WELD_STEP:
                    step_q <= step_clip[14:0];
                `WVS_CMD_WELD_DELAY:
                    delay_q <= delay_clip;
                `WVS_CMD_WELD_PULSE:
                    if (pulse_cnt_q != `WVS_PULSE_DEPTH)
                    begin
                        pulse_cnt_q  <= pulse_cnt_q + 14'd1;
                        pulse_have_q <= 1'b1;
                    end
                default:
                    pend_x_q <= pend_x_q;
            endcase
        end
    end

    // Microsecond prescaler, restarted on every state change
    always @(posedge sys_clk)
    begin
        prev_state_q <= state_q;
        if (rst || prev_state_q != state_q || us_tick)
            pre_q <= 8'h00;
        else
            pre_q <= pre_q + 8'h01;
    end

    // Sequencer
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q          <= ST_IDLE;
            idx_q            <= 15'd0;
            repeat_q         <= 1'b0;
            tgt_x_q          <= 16'h0000;
            tgt_y_q          <= 16'h0000;
            tgt_step_q       <= `WVS_STEP_RST;
            burn_len_q       <= `WVS_PULSE_RST;
            us_cnt_q         <= 16'h0000;
            step_tick_q      <= 1'b0;
            laser_enable_out <= 1'b0;
        end
        else
        begin
            step_tick_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    laser_enable_out <= 1'b0;
                    if (accept && vec_cnt_q != 15'd0 &&
                        (cmd_code == `WVS_CMD_EXEC_LIST || cmd_code == `WVS_CMD_EXEC_REPEAT))
                    begin
                        repeat_q <= (cmd_code == `WVS_CMD_EXEC_REPEAT);
                        idx_q    <= 15'd0;
                        state_q  <= ST_FETCH;
                    end
                end
                ST_FETCH:
                    state_q <= ST_PULSE;
                ST_PULSE:
                    if (pre_q == 8'h01)
                    begin
                        tgt_x_q    <= rd_q[61:46];
                        tgt_y_q    <= rd_q[45:30];
                        tgt_step_q <= rd_q[29:15];
                        burn_len_q <= rd_q[14] ? pulse_rd_q : `WVS_PULSE_RST;
                        us_cnt_q   <= 16'h0000;
                        state_q    <= ST_MOVE;
                    end
                ST_MOVE:
                begin
                    laser_enable_out <= 1'b0;
                    if (at_x && at_y && pre_q != 8'h00)
                    begin
                        us_cnt_q <= delay_q;
                        state_q  <= ST_SETTLE;
                    end
                    else if (us_tick)
                    begin
                        if (us_cnt_q + 16'h0001 >= period)
                        begin
                            us_cnt_q    <= 16'h0000;
                            step_tick_q <= 1'b1;
                        end
                        else
                            us_cnt_q <= us_cnt_q + 16'h0001;
                    end
                end
                ST_SETTLE:
                    if (us_tick)
                    begin
                        if (us_cnt_q == 16'h0001)
                        begin
                            us_cnt_q         <= burn_len_q;
                            laser_enable_out <= 1'b1;
                            state_q          <= ST_BURN;
                        end
                        else
                            us_cnt_q <= us_cnt_q - 16'h0001;
                    end
                ST_BURN:
                    if (us_tick)
                    begin
                        if (us_cnt_q == 16'h0001)
                        begin
                            laser_enable_out <= 1'b0;
                            if (!last_vec)
                            begin
                                idx_q   <= idx_q + 15'd1;
                                state_q <= ST_FETCH;
                            end
                            else if (repeat_q)
                            begin
                                idx_q   <= 15'd0;
                                state_q <= ST_FETCH;
                            end
                            else
                                state_q <= ST_IDLE;
                        end
                        else
                            us_cnt_q <= us_cnt_q - 16'h0001;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Registered outputs
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            cmd_ready  <= 1'b0;
            busy       <= 1'b0;
            weld_x_out <= 16'h0000;
            weld_y_out <= 16'h0000;
            list_full  <= 1'b0;
        end
        else
        begin
            cmd_ready  <= (state_q == ST_IDLE) && !(accept && vec_cnt_q != 15'd0 &&
                          (cmd_code == `WVS_CMD_EXEC_LIST ||
                           cmd_code == `WVS_CMD_EXEC_REPEAT));
            busy       <= (state_q != ST_IDLE);
            weld_x_out <= ax_x;
            weld_y_out <= ax_y;
            list_full  <= (vec_cnt_q == `WVS_VEC_DEPTH) || (pulse_cnt_q == `WVS_PULSE_DEPTH);
        end
    end
endmodule // wvs_top

// ===== wvs_properties.sv
`timescale 1ns/1ps
module wvs_checker (
    input wire        sys_clk,
    input wire        rst,
    input wire        cmd_valid,
    input wire [3:0]  cmd_code,
    input wire [15:0] cmd_arg,
    input wire [15:0] step_period_setting,
    input wire        cmd_ready,
    input wire [15:0] weld_x_out,
    input wire [15:0] weld_y_out,
    input wire        laser_enable_out,
    input wire        busy,
    input wire        list_full
);
    logic [15:0] px_q;
    logic [15:0] py_q;
    logic [23:0] still_q;
    logic [23:0] hi_q;
    wire         moved = (weld_x_out != px_q) || (weld_y_out != py_q);
    wire  [23:0] per_cyc = {8'h00, step_period_setting} * 24'h0000FA;
    always_ff @(posedge sys_clk)
    begin
        px_q <= weld_x_out;
        py_q <= weld_y_out;
        hi_q <= laser_enable_out ? hi_q + 24'h000001 : 24'h000000;
        if (rst)
            still_q <= 24'h7FFFFF;
        else if (moved)
            still_q <= 24'h000000;
        else if (still_q != 24'h7FFFFF)
            still_q <= still_q + 24'h000001;
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_reset_clears_out: assert property (disable iff (1'b0)
        rst |=> !laser_enable_out && !cmd_ready && weld_x_out == 16'h0000)
        else $error("Outputs not cleared by reset");
    a_ready_after_reset: assert property (
        $fell(rst) |-> ##[0:3] cmd_ready) else $error("Ready late after reset");
    a_still_while_lasing: assert property (
        laser_enable_out |-> !moved) else $error("Position moved while lasing");
    a_settle_first: assert property (
        $rose(laser_enable_out) |-> still_q >= 24'h0001EA) else $error("Laser before settle");
    a_pulse_min_len: assert property (
        $fell(laser_enable_out) |-> hi_q >= 24'h00137E) else $error("Laser pulse too short");
    a_step_bounded: assert property (
        moved |-> (weld_x_out > px_q ? weld_x_out - px_q : px_q - weld_x_out) <= 16'h7FFF)
        else $error("Ramp step too large");
    a_step_spacing: assert property (
        moved |-> still_q + 24'h000004 >= per_cyc) else $error("Ramp steps too close");
    a_lasing_blocks_cmds: assert property (
        laser_enable_out |-> busy && !cmd_ready) else $error("Commands open while lasing");
    cover property ($rose(laser_enable_out));
    cover property (moved ##1 !moved);
    cover property ($fell(busy));
endmodule // wvs_checker

// ===== wvs_host.sv
`timescale 1ns/1ps
module wvs_host (
    input  wire         sys_clk,
    input  wire         cmd_ready,
    output logic        cmd_valid,
    output logic [3:0]  cmd_code,
    output logic [15:0] cmd_arg
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_arg = 16'h0000;
    end
    // One code with its argument per command, any order
    task automatic send(input logic [3:0] c, input logic [15:0] a, input bit w);
        int n = 0;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_arg = a;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (w && cmd_ready !== 1'b1 && n < 2000);
    endtask
    task automatic idle();
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_arg = ~cmd_arg;
    endtask
endmodule // wvs_host

// ===== weld_vector_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "wvs_map.vh"
module weld_vector_sequencer_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] step_period_setting = 16'h0001;
    wire         cmd_valid;
    wire  [3:0]  cmd_code;
    wire  [15:0] cmd_arg;
    wire         cmd_ready, laser_enable_out, busy, list_full;
    wire  [15:0] weld_x_out, weld_y_out;
    int          err_total = 0;
    int          n_checks = 0;
    int          exp_x[$], ey[$], ep[$], wl[$];
    logic [15:0] got_x[$], got_y[$], lx;
    int          px = 0, cp = 500, hi = 0, max_dx = 0, rx, ry, n, dx;
    bit          first = 1'b1;
    always #2 sys_clk = ~sys_clk;
    wvs_top i_dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_arg(cmd_arg), .step_period_setting(step_period_setting), .cmd_ready(cmd_ready),
        .weld_x_out(weld_x_out), .weld_y_out(weld_y_out),
        .laser_enable_out(laser_enable_out), .busy(busy), .list_full(list_full));
    wvs_host i_host (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg));
    always @(negedge sys_clk)
    begin
        if (laser_enable_out === 1'b1)
            hi++;
        else if (hi > 0)
        begin
            if (!rst)
            begin
                got_x.push_back(weld_x_out);
                got_y.push_back(weld_y_out);
                wl.push_back(hi);
            end
            hi = 0;
        end
        dx = (weld_x_out > lx) ? weld_x_out - lx : lx - weld_x_out;
        if (first && weld_x_out != lx && dx > max_dx)
            max_dx = dx;
        first = first && laser_enable_out !== 1'b1;
        lx = weld_x_out;
    end
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_len(input int got, input int exp);
        n_checks++;
        if (got < exp || got > exp + 16)
        begin
            err_total++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [3:0] c, input int a);
        i_host.send(c, a[15:0], 1'b1);
        if (c == `WVS_CMD_WELD_X)
            px = a;
        if (c == `WVS_CMD_WELD_PULSE)
            cp = a;
        if (c == `WVS_CMD_WELD_Y)
        begin
            exp_x.push_back(px);
            ey.push_back(a);
            ep.push_back(cp);
        end
    endtask
    task automatic wait_ready();
        n = 0;
        repeat (3) @(negedge sys_clk);
        while (cmd_ready !== 1'b1 && n < 60000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 60000)
            err_total++;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #(95000 * 4);
        err_total++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(32'h560955D8));
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        wait_ready();
        chk_val(laser_enable_out, 1'b0);
        step_period_setting = 16'h0002;
        cmd(`WVS_CMD_EXEC_CLEAR, 0);
        cmd(`WVS_CMD_WELD_STEP, 1000);
        cmd(`WVS_CMD_WELD_DELAY, 2);
        cmd(`WVS_CMD_WELD_PULSE, 20);
        rx = 2000 + $urandom % 2000;
        ry = $urandom % 3000;
        cmd(`WVS_CMD_WELD_X, rx);
        cmd(`WVS_CMD_WELD_Y, ry);
        cmd(`WVS_CMD_WELD_STEP, 32767);
        cmd(`WVS_CMD_WELD_PULSE, 30);
        cmd(`WVS_CMD_WELD_X, 60000);
        cmd(`WVS_CMD_WELD_Y, 100);
        cmd(`WVS_CMD_WELD_X, 0);
        cmd(`WVS_CMD_WELD_Y, 0);
        i_host.send(`WVS_CMD_EXEC_LIST, 16'h0000, 1'b1);
        i_host.idle();
        wait_ready();
        chk_val(got_x.size(), 3);
        for (int i = 0; i < 3 && i < got_x.size(); i++)
        begin
            chk_val(got_x[i], exp_x[i]);
            chk_val(got_y[i], ey[i]);
            chk_len(wl[i], ep[i] * 250);
        end
        chk_val(max_dx, 1000);
        $display("test single_run done");
        got_x.delete();
        got_y.delete();
        wl.delete();
        step_period_setting = 16'h0000;
        i_host.send(`WVS_CMD_EXEC_REPEAT, 16'h0000, 1'b1);
        i_host.send(`WVS_CMD_WELD_PULSE, 16'h4E20, 1'b0);
        i_host.send(`WVS_CMD_EXEC_CLEAR, 16'h0000, 1'b0);
        i_host.idle();
        n = 0;
        while (got_x.size() < 5 && n < 80000)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk_val(cmd_ready, 1'b0);
        for (int i = 0; i < 5 && i < got_x.size(); i++)
        begin
            chk_val(got_x[i], exp_x[i % 3]);
            chk_val(got_y[i], ey[i % 3]);
            chk_len(wl[i], ep[i % 3] * 250);
        end
        $display("test repeat_run done");
        rst = 1'b1;
        repeat (16) @(negedge sys_clk);
        chk_val({laser_enable_out, cmd_ready, weld_x_out}, 18'h00000);
        rst = 1'b0;
        wait_ready();
        chk_val(busy, 1'b0);
        i_host.send(`WVS_CMD_EXEC_LIST, 16'h0000, 1'b1);
        i_host.idle();
        @(negedge sys_clk);
        chk_val({busy, cmd_ready}, 2'b01);
        $display("test reset_stop done");
        for (int i = 0; i <= 16383; i++)
            i_host.send(`WVS_CMD_WELD_PULSE, 16'(20 + $urandom % 256), 1'b1);
        i_host.idle();
        @(negedge sys_clk);
        chk_val(list_full, 1'b1);
        i_host.send(`WVS_CMD_EXEC_CLEAR, 16'h0000, 1'b1);
        i_host.idle();
        @(negedge sys_clk);
        chk_val(list_full, 1'b0);
        $display("test pulse_list done");
        tally_and_finish();
    end
endmodule // weld_vector_sequencer_tb_top
bind wvs_top wvs_checker i_chk (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .step_period_setting(step_period_setting),
    .cmd_ready(cmd_ready), .weld_x_out(weld_x_out), .weld_y_out(weld_y_out),
    .laser_enable_out(laser_enable_out), .busy(busy), .list_full(list_full));
